//--- pkg/ooc_pkg.sv
// Constants and types for the output on/off and margin control block.
// Assumes a byte-wide command/register port driven by the management bus front end.
package ooc_pkg;
  // Command codes
  localparam logic [7:0] OOC_CMD_RUN_MARGIN = 8'h01;
  localparam logic [7:0] OOC_CMD_START_GATE = 8'h02;
  localparam logic [7:0] OOC_CMD_CLR_FAULTS = 8'h03;
  localparam logic [7:0] OOC_CMD_RESTORE = 8'h12;
  // Run/margin control fields
  localparam int OOC_EN_HI = 7;
  localparam int OOC_EN_LO = 6;
  localparam int OOC_MG_HI = 5;
  localparam int OOC_MG_LO = 4;
  localparam int OOC_FH_HI = 3;
  localparam int OOC_FH_LO = 2;
  localparam logic [1:0] OOC_EN_IMM_OFF = 2'h0;
  localparam logic [1:0] OOC_EN_SOFT_OFF = 2'h1;
  localparam logic [1:0] OOC_EN_ON = 2'h2;
  localparam logic [1:0] OOC_MG_NOM = 2'h0;
  localparam logic [1:0] OOC_MG_LOW = 2'h1;
  localparam logic [1:0] OOC_MG_HIGH = 2'h2;
  localparam logic [1:0] OOC_FH_IGNORE = 2'h1;
  localparam logic [1:0] OOC_FH_ACT = 2'h2;
  // Start gating config bits
  localparam int OOC_CF_PWRUP = 4;
  localparam int OOC_CF_BUS = 3;
  localparam int OOC_CF_PIN = 2;
  localparam int OOC_CF_POL = 1;
  localparam int OOC_CF_DACT = 0;
  // Default store contents (reset values)
  localparam logic [7:0] OOC_RUN_DEFAULT = 8'h88;
  localparam logic [7:0] OOC_CFG_DEFAULT = 8'h1e;
  localparam logic [7:0] OOC_CFG_MASK = 8'h1f;
  localparam logic [7:0] OOC_RUN_MASK = 8'hfc;
  // Soft-off timing, in microseconds
  localparam int OOC_CLK_MHZ = 20;
  localparam int OOC_TOFF_DELAY_US = 2000;
  localparam int OOC_TOFF_FALL_US = 200000;
  localparam int OOC_TOFF_DELAY_CYC = OOC_TOFF_DELAY_US * OOC_CLK_MHZ;
  localparam int OOC_TOFF_FALL_CYC = OOC_TOFF_FALL_US * OOC_CLK_MHZ;
  typedef enum logic [1:0] {
    OOC_OFF = 2'b00,
    OOC_RUN = 2'b01,
    OOC_SOFT = 2'b11
  } ooc_state_t;
endpackage : ooc_pkg

//--- hw/ooc_regs.sv
// Holds the two configuration bytes and decodes the action commands.
// Assumes one-cycle write strobes from the bus front end.
`timescale 1ns/1ps
`default_nettype none
module ooc_regs
  import ooc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [7:0] cmd,
  input wire logic [7:0] wdata,
  output logic [7:0] run_q,
  output logic [7:0] cfg_q,
  output logic clr_pulse,
  output logic restore_pulse
);
  logic [7:0] run_d;
  logic [7:0] cfg_d;
  logic rs;
  logic clr_d;
  logic [1:0] en_w, mg_w, fh_w;

  always_comb begin
    en_w = wdata[OOC_EN_HI:OOC_EN_LO];
    mg_w = wdata[OOC_MG_HI:OOC_MG_LO];
    fh_w = wdata[OOC_FH_HI:OOC_FH_LO];
    rs = wr && (cmd == OOC_CMD_RESTORE);
    clr_d = wr && (cmd == OOC_CMD_CLR_FAULTS);
    run_d = run_q;
    cfg_d = cfg_q;
    if (rs) begin
      run_d = OOC_RUN_DEFAULT;
      cfg_d = OOC_CFG_DEFAULT;
    end else if (wr && cmd == OOC_CMD_RUN_MARGIN) begin
      // Reserved codes keep the field as it was
      if (en_w != 2'h3) run_d[OOC_EN_HI:OOC_EN_LO] = en_w;
      if (mg_w != 2'h3) run_d[OOC_MG_HI:OOC_MG_LO] = mg_w;
      if (fh_w == OOC_FH_ACT || fh_w == OOC_FH_IGNORE) begin
        run_d[OOC_FH_HI:OOC_FH_LO] = fh_w;
      end
    end else if (wr && cmd == OOC_CMD_START_GATE) begin
      cfg_d = wdata & OOC_CFG_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= OOC_RUN_DEFAULT;
      cfg_q <= OOC_CFG_DEFAULT;
      clr_pulse <= 1'b0;
      restore_pulse <= 1'b0;
    end else begin
      run_q <= run_d;
      cfg_q <= cfg_d;
      clr_pulse <= clr_d;
      restore_pulse <= rs;
    end
  end
endmodule : ooc_regs
`default_nettype wire

//--- hw/ooc_timer.sv
// Down counter timing the soft-off delay and fall phases.
// Assumes load has priority over counting.
`timescale 1ns/1ps
`default_nettype none
module ooc_timer #(
  parameter int WIDTH = 23
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [WIDTH-1:0] value,
  input wire logic clear,
  output logic done
);
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic busy_q, busy_d, done_d;
  if (WIDTH < 2) begin : g_width_chk
    $error("ooc_timer WIDTH too small");
  end
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (clear) begin
      busy_d = 1'b0;
      cnt_d = '0;
    end else if (load) begin
      cnt_d = value;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= WIDTH'(1)) busy_d = 1'b0;
      else cnt_d = cnt_q - WIDTH'(1);
    end
    // Pulse only when the count runs out, not when cut short
    done_d = busy_q && !busy_d && !clear && !load;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done <= done_d;
    end
  end
endmodule : ooc_timer
`default_nettype wire

//--- hw/ooc_ctrl.sv
// Output on/off and margin control: run decision, soft/immediate off, margin select.
// Assumes the bus front end presents decoded command writes and an input power flag.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Enable 00 immediate off, 01 soft off
// - Enable 10 runs at selected margin
// - Margin selects nominal, low or high target
// - Fault field 10 acts, 01 ignores while margined
// - Power-up bit clear: start whenever powered
// - Power-up bit set: wait for pin/command
// - Bus bit clear ignores command on/off
// - Bus bit set needs command run
// - Pin mode bit requires control pin asserted
// - Polarity bit picks active low or high
// - Pin off: soft or immediate by bit
// - Clear-faults command pulses the FAULTS_CLEAR output
// - Restore command reloads default configuration
module ooc_ctrl
  import ooc_pkg::*;
#(
  parameter int DELAY_CYC = OOC_TOFF_DELAY_CYC,
  parameter int FALL_CYC = OOC_TOFF_FALL_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Command port
  input wire logic CMD_WR,
  input wire logic [7:0] CMD_CODE,
  input wire logic [7:0] CMD_DATA,
  output logic [7:0] RUN_MARGIN_RD,
  output logic [7:0] START_GATE_RD,
  // Inputs from the converter
  input wire logic POWER_PRESENT,
  input wire logic CONTROL_PIN,
  input wire logic OV_UV_EVENT,
  // Power stage control
  output logic OUTPUT_ON,
  output logic FAST_STOP,
  output logic SOFT_RAMP_DOWN,
  output logic [1:0] MARGIN_SEL,
  output logic FAULT_ACT,
  output logic FAULTS_CLEAR,
  output logic DEFAULTS_LOADED
);
  localparam int TW = 23;
  if (DELAY_CYC < 1 || FALL_CYC < 1
      || DELAY_CYC >= (1 << TW) || FALL_CYC >= (1 << TW)) begin : g_cnt_chk
    $error("ooc_ctrl soft-off counts out of range");
  end

  logic [7:0] run_q, cfg_q;
  logic clr_p, rst_p;
  logic tmr_load, tmr_clear, tmr_done;
  logic [TW-1:0] tmr_val;

  ooc_regs u_regs (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .wr(CMD_WR),
    .cmd(CMD_CODE),
    .wdata(CMD_DATA),
    .run_q(run_q),
    .cfg_q(cfg_q),
    .clr_pulse(clr_p),
    .restore_pulse(rst_p)
  );

  ooc_timer #(.WIDTH(TW)) u_tmr (
    .clk(SYS_CLK),
    .rst_n(RESETN),
    .load(tmr_load),
    .value(tmr_val),
    .clear(tmr_clear),
    .done(tmr_done)
  );

  logic [1:0] en_f, mg_f, fh_f;
  logic pin_on, bus_on, gated_on, run_req;
  logic bus_imm_off, pin_imm_off;
  ooc_state_t st_q, st_d;
  logic phase_q, phase_d;
  logic on_d, fast_d, soft_d, fact_d;
  logic [1:0] mg_d;

  always_comb begin
    en_f = run_q[OOC_EN_HI:OOC_EN_LO];
    mg_f = run_q[OOC_MG_HI:OOC_MG_LO];
    fh_f = run_q[OOC_FH_HI:OOC_FH_LO];
    // Polarity-corrected pin
    pin_on = cfg_q[OOC_CF_POL] ? CONTROL_PIN : !CONTROL_PIN;
    bus_on = (en_f == OOC_EN_ON);
    gated_on = (!cfg_q[OOC_CF_BUS] || bus_on)
            && (!cfg_q[OOC_CF_PIN] || pin_on);
    // Power-up bit clear: pin and command ignored
    run_req = POWER_PRESENT && (!cfg_q[OOC_CF_PWRUP] || gated_on);
    bus_imm_off = cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_BUS]
               && (en_f == OOC_EN_IMM_OFF);
    pin_imm_off = cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_PIN] && !pin_on
               && cfg_q[OOC_CF_DACT];
  end

  always_comb begin
    st_d = st_q;
    phase_d = phase_q;
    tmr_load = 1'b0;
    tmr_clear = 1'b0;
    tmr_val = TW'(DELAY_CYC);
    unique case (st_q)
      OOC_OFF: begin
        if (run_req) st_d = OOC_RUN;
      end
      OOC_RUN: begin
        if (!POWER_PRESENT || bus_imm_off || pin_imm_off) begin
          st_d = OOC_OFF;
        end else if (!run_req) begin
          st_d = OOC_SOFT;
          phase_d = 1'b0;
          tmr_load = 1'b1;
        end
      end
      OOC_SOFT: begin
        if (!POWER_PRESENT || bus_imm_off || pin_imm_off) begin
          st_d = OOC_OFF;
          tmr_clear = 1'b1;
        end else if (run_req) begin
          st_d = OOC_RUN;
          tmr_clear = 1'b1;
        end else if (tmr_done && !phase_q) begin
          phase_d = 1'b1;
          tmr_load = 1'b1;
          tmr_val = TW'(FALL_CYC);
        end else if (tmr_done) begin
          st_d = OOC_OFF;
        end
      end
      default: st_d = OOC_OFF;
    endcase
    on_d = (st_d != OOC_OFF);
    fast_d = (st_q != OOC_OFF) && (st_d == OOC_OFF) && (bus_imm_off || pin_imm_off);
    soft_d = (st_d == OOC_SOFT) && phase_d;
    mg_d = (st_d == OOC_RUN) ? mg_f : OOC_MG_NOM;
    // Not margined, or configured to act on over/undervoltage
    fact_d = (mg_f == OOC_MG_NOM) || (fh_f == OOC_FH_ACT);
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= OOC_OFF;
      phase_q <= 1'b0;
      OUTPUT_ON <= 1'b0;
      FAST_STOP <= 1'b0;
      SOFT_RAMP_DOWN <= 1'b0;
      MARGIN_SEL <= OOC_MG_NOM;
      FAULT_ACT <= 1'b1;
      FAULTS_CLEAR <= 1'b0;
      DEFAULTS_LOADED <= 1'b0;
      RUN_MARGIN_RD <= OOC_RUN_DEFAULT;
      START_GATE_RD <= OOC_CFG_DEFAULT;
    end else begin
      st_q <= st_d;
      phase_q <= phase_d;
      OUTPUT_ON <= on_d;
      FAST_STOP <= fast_d;
      SOFT_RAMP_DOWN <= soft_d;
      MARGIN_SEL <= mg_d;
      FAULT_ACT <= fact_d && !OV_UV_EVENT ? 1'b1 : fact_d;
      FAULTS_CLEAR <= clr_p;
      DEFAULTS_LOADED <= rst_p;
      RUN_MARGIN_RD <= run_q;
      START_GATE_RD <= cfg_q;
    end
  end

  // Phase age watches the soft-off timer from outside: a stuck timer would
  // hold the output on for ever, so the assertions below check each phase against its programmed length
  logic [TW-1:0] age_q, age_d;

  always_comb begin
    age_d = '0;
    if (st_q == OOC_SOFT && st_d == OOC_SOFT && phase_d == phase_q) begin
      age_d = age_q + TW'(1);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      age_q <= '0;
    end else begin
      age_q <= age_d;
    end
  end

  // Command-level run with all gates on starts at the next edge
  AST_START: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_OFF && run_req) |=> (st_q == OOC_RUN && OUTPUT_ON))
    else $error("output did not start");
  AST_IMM_BUS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_RUN && bus_imm_off) |=> (st_q == OOC_OFF && !OUTPUT_ON && FAST_STOP))
    else $error("immediate off not taken");
  AST_SOFT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_RUN && !run_req && !bus_imm_off && !pin_imm_off && POWER_PRESENT)
      |=> (st_q == OOC_SOFT && !phase_q))
    else $error("soft off not entered");
  AST_PWRUP: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (!cfg_q[OOC_CF_PWRUP] && POWER_PRESENT && st_q == OOC_OFF) |=> st_q == OOC_RUN)
    else $error("always-on start missed");
  AST_BUS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_BUS] && en_f != OOC_EN_ON && st_q == OOC_OFF)
      |=> st_q == OOC_OFF)
    else $error("started without bus run");
  AST_PIN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_PIN] && !pin_on && st_q == OOC_OFF)
      |=> st_q == OOC_OFF)
    else $error("started without pin");
  AST_MARGIN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_RUN) |=> (st_q != OOC_RUN || MARGIN_SEL == $past(mg_f)))
    else $error("margin select wrong");
  AST_CLR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_CLR_FAULTS) |=> ##1 FAULTS_CLEAR)
    else $error("clear faults missed");
  AST_RESTORE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RESTORE) |=> (run_q == OOC_RUN_DEFAULT
      && cfg_q == OOC_CFG_DEFAULT) ##1 DEFAULTS_LOADED)
    else $error("restore defaults missed");
  AST_RSVD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RUN_MARGIN && CMD_DATA[OOC_EN_HI:OOC_EN_LO] == 2'h3)
      |=> $stable(en_f))
    else $error("reserved enable code changed state");
  AST_RSVD_MG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RUN_MARGIN && CMD_DATA[OOC_MG_HI:OOC_MG_LO] == 2'h3)
      |=> $stable(mg_f))
    else $error("reserved margin code changed state");
  AST_RSVD_FH: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RUN_MARGIN && CMD_DATA[OOC_FH_HI:OOC_FH_LO] != OOC_FH_ACT
      && CMD_DATA[OOC_FH_HI:OOC_FH_LO] != OOC_FH_IGNORE) |=> $stable(fh_f))
    else $error("reserved fault code changed state");
  AST_RUN_WR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RUN_MARGIN && CMD_DATA[OOC_EN_HI:OOC_EN_LO] == OOC_EN_ON)
      |=> en_f == OOC_EN_ON)
    else $error("run code not stored");
  AST_IMM_WR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (CMD_WR && CMD_CODE == OOC_CMD_RUN_MARGIN
      && CMD_DATA[OOC_EN_HI:OOC_EN_LO] == OOC_EN_IMM_OFF) |=> en_f == OOC_EN_IMM_OFF)
    else $error("immediate off code not stored");
  // Losing input power drops the output, with the fast-stop flag only when an immediate-off condition holds in the same cycle
  AST_PWR_LOSS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q != OOC_OFF && !POWER_PRESENT) |=> (st_q == OOC_OFF && !OUTPUT_ON))
    else $error("output kept on without input power");
  AST_FAST_ONE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    FAST_STOP |=> !FAST_STOP)
    else $error("fast stop longer than one cycle");
  AST_MG_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q != OOC_RUN) |-> (MARGIN_SEL == OOC_MG_NOM))
    else $error("margin selected while not running");
  AST_FACT_IGN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (mg_f != OOC_MG_NOM && fh_f == OOC_FH_IGNORE) |=> !FAULT_ACT)
    else $error("faults acted on while told to ignore");
  AST_FACT_ACT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (mg_f == OOC_MG_NOM || fh_f == OOC_FH_ACT) |=> FAULT_ACT)
    else $error("faults ignored while told to act");
  AST_BUS_IGN: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (cfg_q[OOC_CF_PWRUP] && !cfg_q[OOC_CF_BUS] && !cfg_q[OOC_CF_PIN] && POWER_PRESENT)
      |=> st_q == OOC_RUN)
    else $error("command on/off not ignored");
  AST_BUS_ON: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_BUS] && en_f == OOC_EN_ON && POWER_PRESENT
      && (!cfg_q[OOC_CF_PIN] || CONTROL_PIN == cfg_q[OOC_CF_POL])) |=> st_q == OOC_RUN)
    else $error("bus run did not start output");
  AST_POL: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (cfg_q[OOC_CF_PWRUP] && !cfg_q[OOC_CF_BUS] && cfg_q[OOC_CF_PIN] && POWER_PRESENT
      && CONTROL_PIN == cfg_q[OOC_CF_POL]) |=> st_q == OOC_RUN)
    else $error("pin sense not honoured");
  AST_PIN_IMM: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_RUN && cfg_q[OOC_CF_PWRUP] && cfg_q[OOC_CF_PIN] && cfg_q[OOC_CF_DACT]
      && CONTROL_PIN != cfg_q[OOC_CF_POL]) |=> (st_q == OOC_OFF && FAST_STOP))
    else $error("pin immediate off not taken");
  AST_SOFT_BACK: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_SOFT && run_req) |=> st_q == OOC_RUN)
    else $error("run request during soft off ignored");
  AST_OFF_QUIET: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_OFF) |-> (!OUTPUT_ON && !SOFT_RAMP_DOWN))
    else $error("output active while off");
  AST_RAMP_ON: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    SOFT_RAMP_DOWN |-> OUTPUT_ON)
    else $error("ramp shown with output off");
  // Each soft-off phase whose timer runs out ends exactly at its programmed length
  AST_DLY_END: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_SOFT && !phase_q && tmr_done) |-> age_q == TW'(DELAY_CYC))
    else $error("turn-off delay length wrong");
  AST_FALL_END: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_SOFT && phase_q && tmr_done) |-> age_q == TW'(FALL_CYC))
    else $error("fall time length wrong");
  AST_DLY_MAX: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_SOFT && !phase_q) |-> age_q <= TW'(DELAY_CYC))
    else $error("turn-off delay overran");
  AST_FALL_MAX: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (st_q == OOC_SOFT && phase_q) |-> age_q <= TW'(FALL_CYC))
    else $error("fall time overran");
endmodule : ooc_ctrl
`default_nettype wire

//--- dv/ooc_host_model.sv
// Host and control-pin model facing the on/off block's command port.
// Assumes the block's clock; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ooc_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_wr,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_data,
  // Converter side
  output logic power_present,
  output logic control_pin,
  output logic ov_uv_event
);
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 8'h00;
    power_present = 1'b1;
    control_pin = 1'b1;
    ov_uv_event = 1'b0;
  end
  task automatic write(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_data <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    // Released lines show junk, never the last byte
    cmd_code <= ~code;
    cmd_data <= ~data;
  endtask : write
  task automatic set_power(input logic level);
    @(posedge clk);
    power_present <= level;
  endtask : set_power
  task automatic set_pin(input logic level, input logic ev);
    @(posedge clk);
    control_pin <= level;
    ov_uv_event <= ev;
  endtask : set_pin
endmodule : ooc_host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the on/off and margin control block.
// Assumes short soft-off counts so each ramp finishes in a few cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ooc_pkg::*;
  localparam int DLY = 4;
  localparam int FALL = 6;
  logic sys_clk, resetn, cmd_wr, power_present, control_pin, ov_uv_event;
  logic [7:0] cmd_code, cmd_data, run_rd, gate_rd;
  logic output_on, fast_stop, soft_ramp, fault_act, faults_clear, defaults_loaded;
  logic [1:0] margin_sel;
  logic [4:0] obs;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] mg_in [5] = '{8'ha8, 8'h98, 8'h94, 8'hbc, 8'h84};
  logic [7:0] mg_rd [5] = '{8'ha8, 8'h98, 8'h94, 8'h94, 8'h84};
  logic [1:0] mg_sel [5] = '{2'h2, 2'h1, 2'h1, 2'h1, 2'h0};
  logic mg_fa [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  assign obs = {defaults_loaded, faults_clear, soft_ramp, fast_stop, output_on};
  ooc_host_model host_u (.clk(sys_clk), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .power_present(power_present), .control_pin(control_pin),
    .ov_uv_event(ov_uv_event));
  ooc_ctrl #(.DELAY_CYC(DLY), .FALL_CYC(FALL)) dut_u (.SYS_CLK(sys_clk), .RESETN(resetn),
    .CMD_WR(cmd_wr), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data), .RUN_MARGIN_RD(run_rd),
    .START_GATE_RD(gate_rd), .POWER_PRESENT(power_present), .CONTROL_PIN(control_pin),
    .OV_UV_EVENT(ov_uv_event), .OUTPUT_ON(output_on), .FAST_STOP(fast_stop),
    .SOFT_RAMP_DOWN(soft_ramp), .MARGIN_SEL(margin_sel), .FAULT_ACT(fault_act),
    .FAULTS_CLEAR(faults_clear), .DEFAULTS_LOADED(defaults_loaded));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk8
  // Bounded wait for one observed output to reach a level
  task automatic wait_bit(input int idx, input logic v, input int bound);
    bit hit;
    hit = 0;
    total_checks++;
    for (int i = 0; i < bound && !hit; i++) begin
      @(posedge sys_clk);
      #1;
      hit = (obs[idx] === v);
    end
    if (!hit) begin
      bad_count++;
      $display("MISMATCH output bit %0d expected %b seen %b", idx, v, obs[idx]);
      conclude();
    end
  endtask : wait_bit
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle
  // Output must hold through the delay, then ramp, then drop
  task automatic soft_off();
    repeat (2) @(posedge sys_clk);
    #1;
    chk8("on during delay", 8'h01, {7'h0, output_on});
    wait_bit(2, 1'b1, DLY + 6);
    wait_bit(0, 1'b0, FALL + 6);
  endtask : soft_off
  initial begin
    resetn = 1'b0;
    repeat (11) @(posedge sys_clk);
    #1;
    chk8("run reset", OOC_RUN_DEFAULT, run_rd);
    chk8("gate reset", OOC_CFG_DEFAULT, gate_rd);
    chk8("on in reset", 8'h00, {7'h0, output_on});
    @(posedge sys_clk);
    resetn <= 1'b1;
    wait_bit(0, 1'b1, 6);
    $display("test defaults done");
    for (int i = 0; i < 5; i++) begin
      host_u.write(OOC_CMD_RUN_MARGIN, mg_in[i]);
      host_u.set_pin(1'b1, i[0]);
      settle();
      chk8("run rd", mg_rd[i], run_rd);
      chk8("margin sel", {6'h0, mg_sel[i]}, {6'h0, margin_sel});
      chk8("fault act", {7'h0, mg_fa[i]}, {7'h0, fault_act});
      chk8("on margined", 8'h01, {7'h0, output_on});
    end
    $display("test margins done");
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h08);
    wait_bit(1, 1'b1, 4);
    chk8("on after imm", 8'h00, {7'h0, output_on});
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h88);
    wait_bit(0, 1'b1, 6);
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h48);
    soft_off();
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h88);
    wait_bit(0, 1'b1, 6);
    // Run request back inside the delay: no ramp may follow
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h48);
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h88);
    settle();
    settle();
    chk8("on after soft return", 8'h01, {7'h0, output_on});
    chk8("ramp after soft return", 8'h00, {7'h0, soft_ramp});
    host_u.set_power(1'b0);
    wait_bit(0, 1'b0, 4);
    chk8("fast on power loss", 8'h00, {7'h0, fast_stop});
    host_u.set_power(1'b1);
    wait_bit(0, 1'b1, 6);
    $display("test bus off done");
    host_u.set_pin(1'b0, 1'b0);
    soft_off();
    host_u.write(OOC_CMD_START_GATE, 8'h1c);
    wait_bit(0, 1'b1, 6);
    host_u.write(OOC_CMD_START_GATE, 8'h1d);
    host_u.set_pin(1'b1, 1'b0);
    wait_bit(1, 1'b1, 6);
    chk8("on after pin imm", 8'h00, {7'h0, output_on});
    $display("test pin done");
    host_u.write(OOC_CMD_START_GATE, 8'h15);
    host_u.write(OOC_CMD_RUN_MARGIN, 8'h08);
    host_u.set_pin(1'b0, 1'b0);
    wait_bit(0, 1'b1, 6);
    host_u.write(OOC_CMD_START_GATE, 8'h11);
    host_u.set_pin(1'b1, 1'b0);
    settle();
    chk8("pin ignored", 8'h01, {7'h0, output_on});
    host_u.write(OOC_CMD_START_GATE, 8'h0f);
    host_u.set_pin(1'b0, 1'b0);
    settle();
    chk8("always on", 8'h01, {7'h0, output_on});
    host_u.write(OOC_CMD_START_GATE, 8'h1f);
    wait_bit(1, 1'b1, 6);
    $display("test gating done");
    host_u.write(OOC_CMD_CLR_FAULTS, 8'h00);
    wait_bit(3, 1'b1, 4);
    host_u.write(OOC_CMD_RESTORE, 8'h00);
    wait_bit(4, 1'b1, 4);
    settle();
    chk8("run restored", OOC_RUN_DEFAULT, run_rd);
    chk8("gate restored", OOC_CFG_DEFAULT, gate_rd);
    $display("test commands done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
